//--- psr_core_model.sv
`timescale 1ns/1ps
module psr_core_model (
  input wire logic clk_sys,
  input wire logic exc_busy,
  input wire logic exc_go,
  input wire logic [31:0] exc_vec_addr,
  input wire logic mul_done,
  output logic [4:0] core_rd_sel,
  output logic core_wr_en,
  output logic [4:0] core_wr_sel,
  output logic [31:0] core_wr_data,
  output logic core_flag_we,
  output logic [3:0] core_flag_nzvc,
  output logic core_div_we,
  output logic [1:0] core_div_flags,
  output logic core_pc_we,
  output logic [31:0] core_pc_next,
  output logic core_call,
  output logic core_ret,
  output logic core_return_from_interrupt,
  output logic [31:0] core_return_from_interrupt_pc,
  output logic [31:0] core_return_from_interrupt_psw,
  output logic mul_start,
  output logic mul_wide,
  output logic [31:0] mul_a,
  output logic [31:0] mul_b,
  output logic irq_req,
  output logic [4:0] irq_level,
  output logic [7:0] irq_vec,
  output logic trap_req,
  output logic [7:0] trap_vec
);
  initial begin
    {core_wr_en, core_wr_sel, core_wr_data, core_flag_we, core_flag_nzvc, core_div_we, core_div_flags} = '0;
    {core_pc_we, core_pc_next, core_call, core_ret, core_return_from_interrupt, core_return_from_interrupt_pc, core_return_from_interrupt_psw} = '0;
    {mul_start, mul_wide, mul_a, mul_b, irq_req, irq_level, irq_vec, trap_req, trap_vec} = '0;
    core_rd_sel = psr_pkg::SEL_RP;
  end
  // One-cycle core operation: 0 wr, 1 flag, 2 div, 3 pc, 4 call, 5 ret, 6 return_from_interrupt, 7 wide mul, 8 short mul
  task automatic pulse(input int k, input logic [31:0] a, input logic [31:0] b);
    @(posedge clk_sys);
    core_wr_sel <= a[4:0];
    core_wr_data <= b;
    core_flag_nzvc <= a[3:0];
    core_div_flags <= a[1:0];
    core_pc_next <= a;
    core_return_from_interrupt_pc <= a;
    core_return_from_interrupt_psw <= b;
    mul_a <= a;
    mul_b <= b;
    mul_wide <= (k == 7);
    case (k)
      0: core_wr_en <= 1'h1;
      1: core_flag_we <= 1'h1;
      2: core_div_we <= 1'h1;
      3: core_pc_we <= 1'h1;
      4: core_call <= 1'h1;
      5: core_ret <= 1'h1;
      6: core_return_from_interrupt <= 1'h1;
      default: mul_start <= 1'h1;
    endcase
    @(posedge clk_sys);
    {core_wr_en, core_flag_we, core_div_we, core_pc_we, core_call, core_ret, core_return_from_interrupt, mul_start} <= '0;
    if (k >= 7) begin
      repeat (10) begin
        @(posedge clk_sys);
        if (mul_done === 1'h1) break;
      end
    end
  endtask
  // Request held until entry starts or for at most 12 cycles, then dropped
  task automatic exc(input logic trap, input logic [4:0] lvl, input logic [7:0] v, output logic seen,
                     output logic [31:0] va);
    seen = 1'h0;
    va = '0;
    @(posedge clk_sys);
    trap_req <= trap;
    irq_req <= !trap;
    irq_level <= lvl;
    irq_vec <= v;
    trap_vec <= v;
    repeat (12) begin
      @(posedge clk_sys);
      if (exc_busy === 1'h1) break;
    end
    trap_req <= 1'h0;
    irq_req <= 1'h0;
    repeat (8) begin
      @(posedge clk_sys);
      if (exc_go === 1'h1) begin
        seen = 1'h1;
        va = exc_vec_addr;
        break;
      end
    end
  endtask
endmodule // psr_core_model

//--- psr_pkg.sv
package psr_pkg;

  // Reset values
  localparam logic [31:0] SSP_RST = 32'h0000_0000;
  localparam logic [4:0] ILM_RST = 5'h0F;
  localparam logic [31:0] TBR_RST = 32'h000F_FC00;
  localparam logic [6:0] CCR_RST = 7'h00;

  // Status word field positions
  localparam int ILM_LSB = 16;
  localparam int ILM_MSB = 20;
  localparam int SCR_D1 = 10;
  localparam int SCR_D0 = 9;
  localparam int SCR_T = 8;
  localparam int CCR_MSB = 6;
  localparam int CCR_SV = 6;
  localparam int CCR_S = 5;
  localparam int CCR_I = 4;
  localparam int CCR_NZVC_MSB = 3;
  localparam logic [31:0] PSW_MASK = 32'h001F_077F;

  // Core-side register selectors (0 to 15 are general registers)
  localparam logic [4:0] SEL_GPR_SP = 5'h0F;
  localparam logic [4:0] SEL_PSW = 5'h10;
  localparam logic [4:0] SEL_TBR = 5'h11;
  localparam logic [4:0] SEL_RP = 5'h12;
  localparam logic [4:0] SEL_USP = 5'h13;
  localparam logic [4:0] SEL_MDH = 5'h14;
  localparam logic [4:0] SEL_MDL = 5'h15;
  localparam logic [4:0] SEL_PC = 5'h16;
  localparam logic [4:0] SEL_SSP = 5'h17;

  // Bus byte offsets
  localparam logic [7:0] OFS_PSW = 8'h00;
  localparam logic [7:0] OFS_TBR = 8'h04;
  localparam logic [7:0] OFS_RP = 8'h08;
  localparam logic [7:0] OFS_USP = 8'h0C;
  localparam logic [7:0] OFS_MDH = 8'h10;
  localparam logic [7:0] OFS_MDL = 8'h14;
  localparam logic [7:0] OFS_PC = 8'h18;
  localparam logic [7:0] OFS_SSP = 8'h1C;
  localparam logic [7:0] OFS_GPR_BASE = 8'h40;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing
  localparam logic [2:0] MUL_LONG_CYC = 3'h5;
  localparam logic [2:0] MUL_SHORT_CYC = 3'h3;
  localparam int IRQ_RESP_MAX_CYC = 6;
  localparam logic [31:0] STACK_STEP = 32'h0000_0004;

  typedef enum logic [1:0] {
    EX_IDLE = 2'b00,
    EX_PUSH_PSW = 2'b01,
    EX_PUSH_PC = 2'b10,
    EX_VECTOR = 2'b11
  } psr_ex_t;

  typedef struct packed {
    logic [14:0][31:0] gpr;
    logic [31:0] system_stack_pointer;
    logic [31:0] user_stack_pointer;
    logic [31:0] vector_table_base;
    logic [31:0] rp;
    logic [31:0] pc;
    logic [31:0] mdh;
    logic [31:0] mdl;
    logic [4:0] interrupt_priority_mask;
    logic d1;
    logic d0;
    logic t;
    logic [6:0] condition_code_field;
    psr_ex_t ex_state;
    logic ex_busy;
    logic ex_irq;
    logic [4:0] ex_level;
    logic [7:0] ex_vec;
    logic exc_go;
    logic [31:0] exc_vec_addr;
    logic push_we;
    logic [31:0] push_addr;
    logic [31:0] push_data;
    logic [2:0] mul_cnt;
    logic mul_busy;
    logic mul_wide;
    logic [63:0] mul_prod;
    logic mul_done;
    logic [31:0] rd_data;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } psr_state_t;

endpackage

//--- psr_regs.sv
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module psr_regs #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [4:0] core_rd_sel,
  output logic [31:0] core_rd_data,
  input wire logic core_wr_en,
  input wire logic [4:0] core_wr_sel,
  input wire logic [31:0] core_wr_data,
  input wire logic core_flag_we,
  input wire logic [3:0] core_flag_nzvc,
  input wire logic core_div_we,
  input wire logic [1:0] core_div_flags,
  input wire logic core_pc_we,
  input wire logic [31:0] core_pc_next,
  input wire logic core_call,
  input wire logic core_ret,
  input wire logic core_return_from_interrupt,
  input wire logic [31:0] core_return_from_interrupt_pc,
  input wire logic [31:0] core_return_from_interrupt_psw,
  input wire logic mul_start,
  input wire logic mul_wide,
  input wire logic [31:0] mul_a,
  input wire logic [31:0] mul_b,
  output logic mul_busy,
  output logic mul_done,
  input wire logic irq_req,
  input wire logic [4:0] irq_level,
  input wire logic [7:0] irq_vec,
  input wire logic trap_req,
  input wire logic [7:0] trap_vec,
  output logic exc_busy,
  output logic exc_go,
  output logic [31:0] exc_vec_addr,
  output logic push_we,
  output logic [31:0] push_addr,
  output logic [31:0] push_data,
  output logic [31:0] pc_out,
  output logic [4:0] ilm_out,
  output logic [6:0] ccr_out,
  output logic trace_trap_en,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  psr_pkg::psr_state_t st_r;
  psr_pkg::psr_state_t st_nxt;

  // Assembled status word
  function automatic logic [31:0] psw_of(input psr_pkg::psr_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[psr_pkg::ILM_MSB:psr_pkg::ILM_LSB] = s.interrupt_priority_mask;
    w[psr_pkg::SCR_D1] = s.d1;
    w[psr_pkg::SCR_D0] = s.d0;
    w[psr_pkg::SCR_T] = s.t;
    w[psr_pkg::CCR_MSB:0] = s.condition_code_field;
    return w & psr_pkg::PSW_MASK;
  endfunction

  // Register read by selector
  function automatic logic [31:0] reg_get(input psr_pkg::psr_state_t s, input logic [4:0] sel);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (sel < psr_pkg::SEL_GPR_SP) begin
      v = s.gpr[sel[3:0]];
    end else if (sel == psr_pkg::SEL_GPR_SP) begin
      v = s.condition_code_field[psr_pkg::CCR_S] ? s.user_stack_pointer : s.system_stack_pointer;
    end else begin
      unique case (sel)
        psr_pkg::SEL_PSW: v = psw_of(s);
        psr_pkg::SEL_TBR: v = s.vector_table_base;
        psr_pkg::SEL_RP: v = s.rp;
        psr_pkg::SEL_USP: v = s.user_stack_pointer;
        psr_pkg::SEL_MDH: v = s.mdh;
        psr_pkg::SEL_MDL: v = s.mdl;
        psr_pkg::SEL_PC: v = s.pc;
        psr_pkg::SEL_SSP: v = s.system_stack_pointer;
        default: v = 32'h0000_0000;
      endcase
    end
    return v;
  endfunction

  // Register write by selector; dbg marks the debug bus
  function automatic psr_pkg::psr_state_t reg_put(input psr_pkg::psr_state_t s, input logic [4:0] sel,
                                                  input logic [31:0] d, input logic dbg);
    psr_pkg::psr_state_t r;
    r = s;
    if (sel < psr_pkg::SEL_GPR_SP) begin
      r.gpr[sel[3:0]] = d;
    end else if (sel == psr_pkg::SEL_GPR_SP) begin
      if (s.condition_code_field[psr_pkg::CCR_S]) begin
        r.user_stack_pointer = d;
      end else begin
        r.system_stack_pointer = d;
      end
    end else begin
      unique case (sel)
        psr_pkg::SEL_PSW: begin
          r.interrupt_priority_mask = d[psr_pkg::ILM_MSB:psr_pkg::ILM_LSB];
          r.d1 = d[psr_pkg::SCR_D1];
          r.d0 = d[psr_pkg::SCR_D0];
          if (dbg) begin
            r.t = d[psr_pkg::SCR_T];
          end
          r.condition_code_field = d[psr_pkg::CCR_MSB:0];
        end
        psr_pkg::SEL_TBR: r.vector_table_base = d;
        psr_pkg::SEL_RP: r.rp = d;
        psr_pkg::SEL_USP: r.user_stack_pointer = d;
        psr_pkg::SEL_MDH: r.mdh = d;
        psr_pkg::SEL_MDL: r.mdl = d;
        psr_pkg::SEL_SSP: r.system_stack_pointer = d;
        default: r = s;
      endcase
    end
    return r;
  endfunction

  // Bus address to selector, top bit flags a mapped address
  function automatic logic [5:0] bus_sel(input logic [7:0] a);
    logic [5:0] m;
    m = 6'h00;
    if (a[7:6] == psr_pkg::OFS_GPR_BASE[7:6]) begin
      m = {2'b10, a[5:2]};
    end else begin
      unique case ({a[7:2], 2'b00})
        psr_pkg::OFS_PSW: m = {1'b1, psr_pkg::SEL_PSW};
        psr_pkg::OFS_TBR: m = {1'b1, psr_pkg::SEL_TBR};
        psr_pkg::OFS_RP: m = {1'b1, psr_pkg::SEL_RP};
        psr_pkg::OFS_USP: m = {1'b1, psr_pkg::SEL_USP};
        psr_pkg::OFS_MDH: m = {1'b1, psr_pkg::SEL_MDH};
        psr_pkg::OFS_MDL: m = {1'b1, psr_pkg::SEL_MDL};
        psr_pkg::OFS_PC: m = {1'b1, psr_pkg::SEL_PC};
        psr_pkg::OFS_SSP: m = {1'b1, psr_pkg::SEL_SSP};
        default: m = 6'h00;
      endcase
    end
    return m;
  endfunction

  always_comb begin
    logic [5:0] wm;
    logic [5:0] rm;
    logic [31:0] old_v;
    logic [31:0] new_v;
    logic psw_wr;
    logic irq_ok;
    logic [31:0] short_prod;
    wm = bus_sel(st_r.aw_addr);
    rm = bus_sel(s_axi_araddr[7:0]);
    old_v = reg_get(st_r, wm[4:0]);
    new_v = old_v;
    psw_wr = core_wr_en && (core_wr_sel == psr_pkg::SEL_PSW);
    irq_ok = 1'b0;
    short_prod = {16'h0000, mul_a[15:0]} * {16'h0000, mul_b[15:0]};
    st_nxt = st_r;
    st_nxt.push_we = 1'b0;
    st_nxt.exc_go = 1'b0;
    st_nxt.mul_done = 1'b0;

    // Debug bus write, lowest priority against the core
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.aw_have && st_r.w_have && !st_r.bvalid) begin
      for (int i = 0; i < 4; i++) begin
        if (st_r.w_strb[i]) begin
          new_v[i*8 +: 8] = st_r.w_data[i*8 +: 8];
        end
      end
      if (wm[5]) begin
        st_nxt = reg_put(st_nxt, wm[4:0], new_v, 1'b1);
      end
      st_nxt.bresp = wm[5] ? psr_pkg::RESP_OKAY : psr_pkg::RESP_SLVERR;
      st_nxt.bvalid = 1'b1;
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
    end
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_have = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    st_nxt.awready = !st_nxt.aw_have && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_have && !st_nxt.bvalid;

    // Debug bus read
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rm[5] ? reg_get(st_r, rm[4:0]) : 32'h0000_0000;
      st_nxt.rresp = rm[5] ? psr_pkg::RESP_OKAY : psr_pkg::RESP_SLVERR;
    end
    st_nxt.arready = !st_nxt.rvalid;

    // Core read port, value before this edge's writes
    st_nxt.rd_data = reg_get(st_r, core_rd_sel);

    // Core register writes
    if (core_wr_en) begin
      st_nxt = reg_put(st_nxt, core_wr_sel, core_wr_data, 1'b0);
    end
    if (core_flag_we) begin
      st_nxt.condition_code_field[psr_pkg::CCR_NZVC_MSB:0] = core_flag_nzvc;
    end
    // Interim flags kept until the next step; an exception never holds them back
    if (core_div_we) begin
      st_nxt.d1 = core_div_flags[1];
      st_nxt.d0 = core_div_flags[0];
    end

    // Program flow
    if (core_pc_we) begin
      st_nxt.pc = core_pc_next;
    end
    if (core_call) begin
      st_nxt.rp = st_r.pc;
    end
    if (core_ret) begin
      st_nxt.pc = st_r.rp;
    end
    if (core_return_from_interrupt) begin
      st_nxt.pc = core_return_from_interrupt_pc;
      st_nxt = reg_put(st_nxt, psr_pkg::SEL_PSW, core_return_from_interrupt_psw, 1'b0);
      st_nxt.system_stack_pointer = st_r.system_stack_pointer + psr_pkg::STACK_STEP + psr_pkg::STACK_STEP;
    end

    // Exception entry; a status write this cycle is finished first
    irq_ok = irq_req && st_r.condition_code_field[psr_pkg::CCR_I] && (irq_level < st_r.interrupt_priority_mask);
    unique case (st_r.ex_state)
      psr_pkg::EX_IDLE: begin
        if (!psw_wr && !core_return_from_interrupt && (trap_req || irq_ok)) begin
          st_nxt.ex_state = psr_pkg::EX_PUSH_PSW;
          st_nxt.ex_busy = 1'b1;
          st_nxt.ex_irq = !trap_req;
          st_nxt.ex_level = irq_level;
          st_nxt.ex_vec = trap_req ? trap_vec : irq_vec;
        end
      end
      psr_pkg::EX_PUSH_PSW: begin
        st_nxt.push_we = 1'b1;
        st_nxt.push_addr = st_r.system_stack_pointer - psr_pkg::STACK_STEP;
        st_nxt.push_data = psw_of(st_r);
        st_nxt.system_stack_pointer = st_r.system_stack_pointer - psr_pkg::STACK_STEP;
        st_nxt.ex_state = psr_pkg::EX_PUSH_PC;
      end
      psr_pkg::EX_PUSH_PC: begin
        st_nxt.push_we = 1'b1;
        st_nxt.push_addr = st_r.system_stack_pointer - psr_pkg::STACK_STEP;
        st_nxt.push_data = st_r.pc;
        st_nxt.system_stack_pointer = st_r.system_stack_pointer - psr_pkg::STACK_STEP;
        st_nxt.ex_state = psr_pkg::EX_VECTOR;
      end
      psr_pkg::EX_VECTOR: begin
        st_nxt.exc_go = 1'b1;
        st_nxt.exc_vec_addr = st_r.vector_table_base + {22'h00_0000, ~st_r.ex_vec, 2'b00};
        if (st_r.ex_irq) begin
          st_nxt.interrupt_priority_mask = st_r.ex_level;
        end
        st_nxt.condition_code_field[psr_pkg::CCR_S] = 1'b0;
        st_nxt.ex_busy = 1'b0;
        st_nxt.ex_state = psr_pkg::EX_IDLE;
      end
    endcase

    // Multiplier with fixed latency
    if (st_r.mul_cnt != 3'h0) begin
      st_nxt.mul_cnt = st_r.mul_cnt - 3'h1;
      if (st_r.mul_cnt == 3'h1) begin
        st_nxt.mul_done = 1'b1;
        st_nxt.mdl = st_r.mul_prod[31:0];
        if (st_r.mul_wide) begin
          st_nxt.mdh = st_r.mul_prod[63:32];
        end
      end
    end else if (mul_start) begin
      st_nxt.mul_wide = mul_wide;
      st_nxt.mul_cnt = mul_wide ? psr_pkg::MUL_LONG_CYC : psr_pkg::MUL_SHORT_CYC;
      st_nxt.mul_prod = mul_wide ? (64'(mul_a) * 64'(mul_b)) : {32'h0000_0000, short_prod};
    end
    st_nxt.mul_busy = (st_nxt.mul_cnt != 3'h0);
  end

  // Only registers with a defined reset value are loaded at reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r.system_stack_pointer <= psr_pkg::SSP_RST;
      st_r.interrupt_priority_mask <= psr_pkg::ILM_RST;
      st_r.vector_table_base <= psr_pkg::TBR_RST;
      st_r.condition_code_field <= psr_pkg::CCR_RST;
      st_r.d1 <= 1'b0;
      st_r.d0 <= 1'b0;
      st_r.t <= 1'b0;
      st_r.ex_state <= psr_pkg::EX_IDLE;
      st_r.ex_busy <= 1'b0;
      st_r.ex_irq <= 1'b0;
      st_r.ex_level <= 5'h00;
      st_r.ex_vec <= 8'h00;
      st_r.exc_go <= 1'b0;
      st_r.exc_vec_addr <= 32'h0000_0000;
      st_r.push_we <= 1'b0;
      st_r.push_addr <= 32'h0000_0000;
      st_r.push_data <= 32'h0000_0000;
      st_r.mul_cnt <= 3'h0;
      st_r.mul_wide <= 1'b0;
      st_r.mul_busy <= 1'b0;
      st_r.mul_done <= 1'b0;
      st_r.rd_data <= 32'h0000_0000;
      st_r.aw_have <= 1'b0;
      st_r.aw_addr <= 8'h00;
      st_r.w_have <= 1'b0;
      st_r.w_data <= 32'h0000_0000;
      st_r.w_strb <= 4'h0;
      st_r.awready <= 1'b0;
      st_r.wready <= 1'b0;
      st_r.bvalid <= 1'b0;
      st_r.bresp <= 2'h0;
      st_r.arready <= 1'b0;
      st_r.rvalid <= 1'b0;
      st_r.rdata <= 32'h0000_0000;
      st_r.rresp <= 2'h0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign core_rd_data = st_r.rd_data;
  assign mul_busy = st_r.mul_busy;
  assign mul_done = st_r.mul_done;
  assign exc_busy = st_r.ex_busy;
  assign exc_go = st_r.exc_go;
  assign exc_vec_addr = st_r.exc_vec_addr;
  assign push_we = st_r.push_we;
  assign push_addr = st_r.push_addr;
  assign push_data = st_r.push_data;
  assign pc_out = st_r.pc;
  assign ilm_out = st_r.interrupt_priority_mask;
  assign ccr_out = st_r.condition_code_field;
  assign trace_trap_en = st_r.t;
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rvalid = st_r.rvalid;

endmodule // psr_regs

//--- psr_regs_properties.sv
`timescale 1ns/1ps
module psr_regs_checker (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [4:0] core_rd_sel,
  input wire logic [31:0] core_rd_data,
  input wire logic core_wr_en,
  input wire logic core_flag_we,
  input wire logic [3:0] core_flag_nzvc,
  input wire logic core_pc_we,
  input wire logic [31:0] core_pc_next,
  input wire logic core_call,
  input wire logic core_ret,
  input wire logic core_return_from_interrupt,
  input wire logic mul_start,
  input wire logic mul_wide,
  input wire logic mul_busy,
  input wire logic mul_done,
  input wire logic irq_req,
  input wire logic [4:0] irq_level,
  input wire logic trap_req,
  input wire logic exc_busy,
  input wire logic exc_go,
  input wire logic [31:0] pc_out,
  input wire logic [4:0] ilm_out,
  input wire logic [6:0] ccr_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_call_rp;
    core_call ##1 (core_rd_sel == psr_pkg::SEL_RP && !core_call && !core_wr_en);
  endsequence
  sequence s_mul_go;
    mul_start && !mul_busy;
  endsequence
  property p_call_rp;
    s_call_rp |=> core_rd_data == $past(pc_out, 2);
  endproperty
  a_call_rp: assert property (p_call_rp) else $error("return pointer not loaded");
  property p_pc_load;
    core_pc_we && !core_ret && !core_return_from_interrupt && !exc_busy |=> pc_out == $past(core_pc_next);
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("pc not loaded");
  property p_mul_long;
    s_mul_go and mul_wide |=> mul_busy[*5] ##1 mul_done;
  endproperty
  a_mul_long: assert property (p_mul_long) else $error("long multiply timing");
  property p_mul_short;
    s_mul_go and !mul_wide |=> mul_busy[*3] ##1 mul_done;
  endproperty
  a_mul_short: assert property (p_mul_short) else $error("short multiply timing");
  property p_trap_resp;
    trap_req && !exc_busy && !core_return_from_interrupt && !core_wr_en |-> ##[1:6] exc_go;
  endproperty
  a_trap_resp: assert property (p_trap_resp) else $error("exception response late");
  property p_irq_mask;
    irq_req && !trap_req && !exc_busy && irq_level >= ilm_out |=> !exc_busy;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt taken");
  property p_flags;
    core_flag_we && !core_wr_en && !core_return_from_interrupt && !exc_busy |=> ccr_out[3:0] == $past(core_flag_nzvc);
  endproperty
  a_flags: assert property (p_flags) else $error("condition flags not loaded");
  property p_reset;
    $rose(reset_n) |-> ilm_out == psr_pkg::ILM_RST && ccr_out == psr_pkg::CCR_RST;
  endproperty
  a_reset: assert property (p_reset) else $error("status reset value wrong");
endmodule // psr_regs_checker
bind psr_regs psr_regs_checker psr_regs_checker_inst (.*);

//--- tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin error_cnt++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module tb;
  logic clk_sys = 1'h0;
  logic reset_n = 1'h0;
  logic core_wr_en, core_flag_we, core_div_we, core_pc_we, core_call, core_ret, core_return_from_interrupt;
  logic mul_start, mul_wide, mul_busy, mul_done, irq_req, trap_req, exc_busy, exc_go, push_we, trace_trap_en;
  logic [4:0] core_rd_sel, core_wr_sel, irq_level, ilm_out;
  logic [31:0] core_rd_data, core_wr_data, core_pc_next, core_return_from_interrupt_pc, core_return_from_interrupt_psw, mul_a, mul_b;
  logic [31:0] exc_vec_addr, push_addr, push_data, pc_out, s_axi_wdata, s_axi_rdata, sd, a, b, va;
  logic [3:0] core_flag_nzvc, s_axi_wstrb;
  logic [1:0] core_div_flags, s_axi_bresp, s_axi_rresp;
  logic [7:0] irq_vec, trap_vec, s_axi_awaddr, s_axi_araddr;
  logic [6:0] ccr_out;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, seen;
  logic [63:0] p;
  logic [31:0] m [logic [7:0]];
  logic [31:0] push_exp = 32'h0000_0FFC;
  int error_cnt = 0;
  int n_compared = 0;
  psr_regs psr_regs_inst (.*);
  psr_core_model psr_core_model_inst (.*);
  always #2.5 clk_sys = ~clk_sys;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return (s >> 1) ^ (s[0] ? 32'h8020_0003 : 32'h0);
  endfunction
  function automatic logic [7:0] key(input logic [7:0] ad);
    return (ad == 8'h7C) ? (m[8'h0][5] ? psr_pkg::OFS_USP : psr_pkg::OFS_SSP) : ad;
  endfunction
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wc(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    @(posedge clk_sys);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    repeat (50) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        break;
      end
    end
    `CHK("bresp", er, r)
    if (er == psr_pkg::RESP_OKAY && ad != psr_pkg::OFS_PC) m[key(ad)] = (ad == 8'h0) ? d & psr_pkg::PSW_MASK : d;
  endtask
  task automatic rc(input logic [7:0] ad, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] k;
    k = key(ad);
    @(posedge clk_sys);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    repeat (50) begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        break;
      end
    end
    `CHK("rdata", m[k], d)
    `CHK("rresp", er, r)
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    report_and_stop();
  end
  always @(posedge clk_sys) begin
    if (push_we === 1'h1) begin
      `CHK("push addr", push_exp, push_addr)
      push_exp = push_exp - psr_pkg::STACK_STEP;
    end
  end
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    sd = 32'h13;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'h1;
    repeat (2) @(posedge clk_sys);
    m[8'h0] = 32'h000F_0000;
    m[psr_pkg::OFS_TBR] = psr_pkg::TBR_RST;
    m[psr_pkg::OFS_SSP] = 32'h0;
    m[8'h20] = 32'h0;
    rc(8'h0, psr_pkg::RESP_OKAY);
    rc(psr_pkg::OFS_TBR, psr_pkg::RESP_OKAY);
    rc(8'h7C, psr_pkg::RESP_OKAY);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      sd = lfsr(sd);
      wc(8'h40 + 8'(i * 12), sd, psr_pkg::RESP_OKAY);
      rc(8'h40 + 8'(i * 12), psr_pkg::RESP_OKAY);
    end
    for (int i = 1; i < 4; i++) begin
      sd = lfsr(sd);
      wc(8'(i * 4), sd, psr_pkg::RESP_OKAY);
      rc(8'(i * 4), psr_pkg::RESP_OKAY);
    end
    wc(8'h20, sd, psr_pkg::RESP_SLVERR);
    rc(8'h20, psr_pkg::RESP_SLVERR);
    $display("register test done");
    wc(8'h0, 32'hFFFF_FFFF, psr_pkg::RESP_OKAY);
    rc(8'h0, psr_pkg::RESP_OKAY);
    rc(8'h7C, psr_pkg::RESP_OKAY);
    psr_core_model_inst.pulse(0, 32'(psr_pkg::SEL_PSW), 32'h0);
    m[8'h0] = 32'h0000_0100;
    rc(8'h0, psr_pkg::RESP_OKAY);
    `CHK("trace", 1'h1, trace_trap_en)
    wc(8'h0, 32'h000F_0010, psr_pkg::RESP_OKAY);
    rc(8'h7C, psr_pkg::RESP_OKAY);
    psr_core_model_inst.pulse(2, 32'h3, 32'h0);
    m[8'h0] = m[8'h0] | 32'h0000_0600;
    rc(8'h0, psr_pkg::RESP_OKAY);
    psr_core_model_inst.pulse(1, 32'h5, 32'h0);
    m[8'h0] = m[8'h0] | 32'h5;
    rc(8'h0, psr_pkg::RESP_OKAY);
    $display("status test done");
    sd = lfsr(sd);
    psr_core_model_inst.pulse(3, sd, 32'h0);
    m[psr_pkg::OFS_PC] = sd;
    psr_core_model_inst.pulse(4, 32'h0, 32'h0);
    m[psr_pkg::OFS_RP] = sd;
    rc(psr_pkg::OFS_RP, psr_pkg::RESP_OKAY);
    `CHK("rd port", m[psr_pkg::OFS_RP], core_rd_data)
    wc(psr_pkg::OFS_RP, lfsr(sd), psr_pkg::RESP_OKAY);
    psr_core_model_inst.pulse(5, 32'h0, 32'h0);
    m[psr_pkg::OFS_PC] = lfsr(sd);
    wc(psr_pkg::OFS_PC, 32'h0, psr_pkg::RESP_OKAY);
    rc(psr_pkg::OFS_PC, psr_pkg::RESP_OKAY);
    $display("call test done");
    for (int w = 0; w < 2; w++) begin
      a = lfsr(sd);
      b = lfsr(a);
      sd = b;
      psr_core_model_inst.pulse(8 - w, a, b);
      p = (w == 1) ? {32'h0, a} * {32'h0, b} : {m[psr_pkg::OFS_MDH], 32'h0 + a[15:0] * b[15:0]};
      {m[psr_pkg::OFS_MDH], m[psr_pkg::OFS_MDL]} = p;
      if (w == 1) rc(psr_pkg::OFS_MDH, psr_pkg::RESP_OKAY);
      rc(psr_pkg::OFS_MDL, psr_pkg::RESP_OKAY);
    end
    $display("multiply test done");
    wc(psr_pkg::OFS_SSP, 32'h0000_1000, psr_pkg::RESP_OKAY);
    psr_core_model_inst.exc(1'h1, 5'h0, 8'h2A, seen, va);
    `CHK("trap", 1'h1, seen)
    `CHK("vector", m[psr_pkg::OFS_TBR] + 32'h3FC - 32'hA8, va)
    m[psr_pkg::OFS_SSP] = 32'h0000_0FF8;
    rc(psr_pkg::OFS_SSP, psr_pkg::RESP_OKAY);
    psr_core_model_inst.pulse(6, 32'h0000_0200, 32'h000F_0010);
    m[psr_pkg::OFS_SSP] = 32'h0000_1000;
    m[psr_pkg::OFS_PC] = 32'h0000_0200;
    m[8'h0] = 32'h000F_0010;
    rc(psr_pkg::OFS_SSP, psr_pkg::RESP_OKAY);
    rc(psr_pkg::OFS_USP, psr_pkg::RESP_OKAY);
    rc(psr_pkg::OFS_PC, psr_pkg::RESP_OKAY);
    wc(8'h0, 32'h0008_0010, psr_pkg::RESP_OKAY);
    psr_core_model_inst.exc(1'h0, 5'h08, 8'h40, seen, va);
    `CHK("masked", 1'h0, seen)
    push_exp = 32'h0000_0FFC;
    psr_core_model_inst.exc(1'h0, 5'h03, 8'h40, seen, va);
    `CHK("irq", 1'h1, seen)
    m[8'h0] = 32'h0003_0010;
    m[psr_pkg::OFS_SSP] = 32'h0000_0FF8;
    rc(8'h0, psr_pkg::RESP_OKAY);
    rc(psr_pkg::OFS_SSP, psr_pkg::RESP_OKAY);
    `CHK("pushes", 32'h0000_0FF4, push_exp)
    $display("exception test done");
    report_and_stop();
  end
endmodule // tb
